// file: verilog/mhc_pkg.sv
// Package of constants and carrier types for the modem handshake control block
package mhc_pkg;

  // *************************************************************************
  // Timing
  // *************************************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICKS_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BREAK_MS = 233;
  localparam int unsigned DISC_PULSE_MS = 70;
  localparam int unsigned RING_TIMEOUT_S = 15;
  localparam int unsigned LOSS_TIMEOUT_S = 5;
  localparam int unsigned RING_TIMEOUT_MS = RING_TIMEOUT_S * 1000;
  localparam int unsigned LOSS_TIMEOUT_MS = LOSS_TIMEOUT_S * 1000;
  localparam int unsigned MS_CNT_W = 18;
  localparam int unsigned DUR_W = 14;

  // Permit line levels
  typedef enum logic [1:0] {MHC_LVL_ZERO, MHC_LVL_MID, MHC_LVL_HIGH} mhc_level_t;

  // Terminal status group
  typedef struct packed {
    logic paper_ok;
    logic on_line;
    logic power_ok;
    logic wake_done;
  } mhc_term_t;

  // Modem status group
  typedef struct packed {
    logic cts;
    logic dcd;
    logic ri;
  } mhc_modem_t;

  // Modem control group
  typedef struct packed {
    logic rts;
    logic dtr;
    logic originate;
  } mhc_ctrl_t;

endpackage

// file: verilog/mhc_pulse_timer.sv
// Millisecond-based one-shot timer used for pulses and timeouts
`timescale 1ns/1ps
module mhc_pulse_timer #(
  parameter int unsigned TICKS_PER_MS = mhc_pkg::TICKS_PER_MS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [mhc_pkg::DUR_W-1:0] i_dur_ms,
  output logic o_busy,
  output logic o_done
);

  logic [mhc_pkg::MS_CNT_W-1:0] tick_reg;
  logic [mhc_pkg::DUR_W-1:0] ms_reg;
  logic busy_reg;
  logic done_reg;
  logic ms_wrap;

  assign ms_wrap = (tick_reg == mhc_pkg::MS_CNT_W'(TICKS_PER_MS - 1));

  // Count ticks, then milliseconds, while running
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tick_reg <= '0;
      ms_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (i_abort)
      begin
        busy_reg <= 1'b0;
        tick_reg <= '0;
        ms_reg <= '0;
      end
      else if (i_start && !busy_reg)
      begin
        busy_reg <= 1'b1;
        tick_reg <= '0;
        ms_reg <= '0;
      end
      else if (busy_reg)
      begin
        if (ms_wrap)
        begin
          tick_reg <= '0;
          if (ms_reg == i_dur_ms - mhc_pkg::DUR_W'(1))
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
          else
          begin
            ms_reg <= ms_reg + mhc_pkg::DUR_W'(1);
          end
        end
        else
        begin
          tick_reg <= tick_reg + mhc_pkg::MS_CNT_W'(1);
        end
      end
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;

endmodule

// file: verilog/mhc_top.sv
// Terminal-side modem handshake control: permit line, RTS, originate, pulses
`timescale 1ns/1ps
module mhc_top #(
  parameter int unsigned TICKS_PER_MS = mhc_pkg::TICKS_PER_MS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire mhc_pkg::mhc_term_t i_term,
  input wire mhc_pkg::mhc_modem_t i_modem,
  input wire logic i_key_data,
  input wire logic i_master_req,
  input wire logic i_permit_zero,
  input wire logic i_answerback_req,
  input wire logic i_break_inject_jumper,
  input wire logic i_status_follow_jumper,
  input wire logic i_switched_net,
  output logic o_tx_data,
  output mhc_pkg::mhc_ctrl_t o_modem,
  output logic o_permit_mid_oe,
  output logic o_permit_high_oe,
  output mhc_pkg::mhc_level_t o_permit_level,
  output logic o_kbd_enable,
  output logic o_select_lamp,
  output logic o_answerback_send
);

  // *************************************************************************
  // Input synchronisers
  // *************************************************************************
  localparam int unsigned NSYNC = 11;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync_in;
  mhc_pkg::mhc_term_t term_s;
  mhc_pkg::mhc_modem_t modem_s;
  logic key_s;
  logic master_s;
  logic zero_s;
  logic ab_req_s;

  assign sync_in = {i_term, i_modem, i_key_data, i_master_req, i_permit_zero,
    i_answerback_req};

  // Two flops on every pin input except the jumpers and i_switched_net
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign {term_s, modem_s, key_s, master_s, zero_s, ab_req_s} = sync2_reg;

  // *************************************************************************
  // Terminal readiness
  // *************************************************************************
  logic ready;
  logic local_mode;
  logic ready_d_reg;
  logic ready_fall;

  // Ready needs all four conditions
  assign ready = term_s.paper_ok & term_s.on_line & term_s.power_ok
    & term_s.wake_done;
  assign local_mode = term_s.power_ok & ~term_s.on_line;

  // Previous ready for edge detection
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      ready_d_reg <= 1'b0;
    else
      ready_d_reg <= ready;
  end

  assign ready_fall = ready_d_reg & ~ready;

  // *************************************************************************
  // Break limiter and not-ready pulse
  // *************************************************************************
  logic brk_busy;
  logic brk_done;
  logic brk_cut_reg;
  logic nr_busy;
  logic nr_pulse;

  mhc_pulse_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_brk_tmr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(key_s && !brk_cut_reg),
    .i_abort(!key_s),
    .i_dur_ms(mhc_pkg::DUR_W'(mhc_pkg::BREAK_MS)),
    .o_busy(brk_busy),
    .o_done(brk_done)
  );

  // Hold break off once limit reached, until key releases
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      brk_cut_reg <= 1'b0;
    else if (!key_s)
      brk_cut_reg <= 1'b0;
    else if (brk_done)
      brk_cut_reg <= 1'b1;
  end

  // Not-ready pulse starts on ready fall, ends early if ready returns
  mhc_pulse_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_nr_tmr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(ready_fall),
    .i_abort(ready && !ready_fall),
    .i_dur_ms(mhc_pkg::DUR_W'(mhc_pkg::BREAK_MS)),
    .o_busy(nr_busy),
    .o_done()
  );

  assign nr_pulse = nr_busy & i_break_inject_jumper;

  logic tx_reg;
  // Outgoing data: limited break or injected not-ready pulse
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      tx_reg <= 1'b0;
    else
      tx_reg <= (key_s & ~brk_cut_reg) | nr_pulse;
  end

  // *************************************************************************
  // Permit line
  // *************************************************************************
  logic want_high;
  mhc_pkg::mhc_level_t level;
  mhc_pkg::mhc_level_t level_reg;
  logic mid_oe_reg;
  logic high_oe_reg;

  assign want_high = modem_s.cts | local_mode;

  // Resolve line: option 0 overrides device drive
  always_comb
  begin
    if (zero_s)
      level = mhc_pkg::MHC_LVL_ZERO;
    else if (want_high)
      level = mhc_pkg::MHC_LVL_HIGH;
    else
      level = mhc_pkg::MHC_LVL_MID;
  end

  // Device drives only M or H
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      mid_oe_reg <= 1'b1;
      high_oe_reg <= 1'b0;
      level_reg <= mhc_pkg::MHC_LVL_MID;
    end
    else
    begin
      mid_oe_reg <= ~want_high;
      high_oe_reg <= want_high;
      level_reg <= level;
    end
  end

  // *************************************************************************
  // Level effects and modem handshake
  // *************************************************************************
  logic kbd_reg;
  logic lamp_reg;
  logic rts_reg;
  logic ab_pend_reg;
  logic ab_send_reg;
  logic ab_req_d_reg;
  logic ab_rise;

  assign ab_rise = ab_req_s & ~ab_req_d_reg;

  // Keyboard, lamp and RTS follow resolved level
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      kbd_reg <= 1'b0;
      lamp_reg <= 1'b0;
      rts_reg <= 1'b0;
    end
    else
    begin
      kbd_reg <= (level != mhc_pkg::MHC_LVL_ZERO);
      lamp_reg <= (level == mhc_pkg::MHC_LVL_HIGH);
      rts_reg <= ready && (level != mhc_pkg::MHC_LVL_ZERO);
    end
  end

  // Answerback: ignore in 0, hold in M, send in H
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ab_req_d_reg <= 1'b0;
      ab_pend_reg <= 1'b0;
      ab_send_reg <= 1'b0;
    end
    else
    begin
      ab_req_d_reg <= ab_req_s;
      ab_send_reg <= 1'b0;
      if (level == mhc_pkg::MHC_LVL_ZERO)
        ab_pend_reg <= 1'b0;
      else if (level == mhc_pkg::MHC_LVL_HIGH && (ab_rise || ab_pend_reg))
      begin
        ab_send_reg <= 1'b1;
        ab_pend_reg <= 1'b0;
      end
      else if (ab_rise)
        ab_pend_reg <= 1'b1;
    end
  end

  // *************************************************************************
  // Originate request
  // *************************************************************************
  logic orig_reg;

  // Master request passes through; its drop ends originate
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      orig_reg <= 1'b0;
    else
      orig_reg <= master_s;
  end

  // *************************************************************************
  // Disconnect timers
  // *************************************************************************
  logic ri_d_reg;
  logic ring_rise;
  logic conn_reg;
  logic dcd_d_reg;
  logic ring_busy;
  logic ring_done;
  logic loss_busy;
  logic loss_done;
  logic disc_busy;
  logic disc_start;

  assign ring_rise = modem_s.ri & ~ri_d_reg;

  // Track ring edge and established connection
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ri_d_reg <= 1'b0;
      dcd_d_reg <= 1'b0;
      conn_reg <= 1'b0;
    end
    else
    begin
      ri_d_reg <= modem_s.ri;
      dcd_d_reg <= modem_s.dcd;
      if (modem_s.dcd)
        conn_reg <= 1'b1;
      else if (loss_done || ring_done)
        conn_reg <= 1'b0;
    end
  end

  mhc_pulse_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_ring_tmr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(ring_rise && i_switched_net),
    .i_abort(1'b0),
    .i_dur_ms(mhc_pkg::DUR_W'(mhc_pkg::RING_TIMEOUT_MS)),
    .o_busy(ring_busy),
    .o_done(ring_done)
  );

  mhc_pulse_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_loss_tmr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(conn_reg && dcd_d_reg && !modem_s.dcd && i_switched_net),
    .i_abort(modem_s.dcd),
    .i_dur_ms(mhc_pkg::DUR_W'(mhc_pkg::LOSS_TIMEOUT_MS)),
    .o_busy(loss_busy),
    .o_done(loss_done)
  );

  assign disc_start = (ring_done && !modem_s.dcd) || loss_done;

  mhc_pulse_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_disc_tmr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(disc_start),
    .i_abort(1'b0),
    .i_dur_ms(mhc_pkg::DUR_W'(mhc_pkg::DISC_PULSE_MS)),
    .o_busy(disc_busy),
    .o_done()
  );

  logic dtr_reg;
  // DTR low during disconnect pulse or, with follow jumper, while not ready
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      dtr_reg <= 1'b0;
    else
      dtr_reg <= ~disc_busy & (ready | ~i_status_follow_jumper);
  end

  // *************************************************************************
  // Outputs
  // *************************************************************************
  assign o_tx_data = tx_reg;
  assign o_modem = '{rts: rts_reg, dtr: dtr_reg, originate: orig_reg};
  assign o_permit_mid_oe = mid_oe_reg;
  assign o_permit_high_oe = high_oe_reg;
  assign o_permit_level = level_reg;
  assign o_kbd_enable = kbd_reg;
  assign o_select_lamp = lamp_reg;
  assign o_answerback_send = ab_send_reg;

  // *************************************************************************
  // Assertions
  // *************************************************************************
  AST_NEVER_BOTH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(o_permit_mid_oe && o_permit_high_oe))
    else $error("device drives both M and H");
  AST_ZERO_WINS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    zero_s |=> o_permit_level == mhc_pkg::MHC_LVL_ZERO)
    else $error("zero drive did not win");
  AST_KBD_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    level == mhc_pkg::MHC_LVL_ZERO |=> !o_kbd_enable && !o_modem.rts)
    else $error("keyboard or rts active in zero state");
  AST_LAMP_H: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_select_lamp |-> $past(level) == mhc_pkg::MHC_LVL_HIGH)
    else $error("lamp lit outside high");
  AST_RTS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ready && level == mhc_pkg::MHC_LVL_MID) |=> o_modem.rts)
    else $error("rts missing at mid with ready");
  AST_CTS_HIGH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (modem_s.cts && !zero_s) |=> o_permit_high_oe)
    else $error("cts did not raise line");
  AST_LOCAL_HIGH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (local_mode && !zero_s) |=> o_permit_level == mhc_pkg::MHC_LVL_HIGH)
    else $error("local mode not high");
  AST_ORIG: assert property (@(posedge i_core_clk) disable iff (i_rst)
    master_s |=> o_modem.originate)
    else $error("originate not passed");
  AST_NOINJ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!i_break_inject_jumper && !key_s) |=> !o_tx_data)
    else $error("pulse injected without jumper");
  AST_FOLLOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_status_follow_jumper && !ready) |=> !o_modem.dtr)
    else $error("dtr high while not ready");
endmodule

// file: bench/mhc_far_side.sv
// Behavioural far side: modem answering RTS with CTS, addressing option on the permit line
`timescale 1ns/1ps
module mhc_far_side (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_rts,
  input wire logic i_cts_enable,
  input wire logic [7:0] i_cts_delay,
  input wire logic i_option_fitted,
  input wire logic i_toggle,
  output logic o_cts,
  output logic o_permit_zero,
  output logic o_master_req
);
  logic [7:0] wait_reg;
  logic master_reg;

  // Modem raises CTS a set number of cycles after RTS and drops it with RTS
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !i_rts || !i_cts_enable)
    begin
      wait_reg <= 8'h00;
      o_cts <= 1'b0;
    end
    else if (wait_reg >= i_cts_delay)
      o_cts <= 1'b1;
    else
      wait_reg <= wait_reg + 8'h01;
  end

  // Option flips master role on each toggle keystroke
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      master_reg <= 1'b0;
    else if (i_toggle)
      master_reg <= ~master_reg;
  end

  // Option only ever pulls the line to zero, and not at all when absent
  assign o_master_req = master_reg;
  assign o_permit_zero = i_option_fitted & ~master_reg;
endmodule

// file: bench/test_mhc_top.sv
// Self-checking bench for the modem handshake control block
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
  begin \
    total_checks++; \
    if ((ac) !== (ex)) \
    begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, ex, ac); \
    end \
  end
module test_mhc_top;
  localparam int unsigned TPM = 2;
  localparam int BRK = 233 * TPM;
  localparam mhc_pkg::mhc_level_t LZ = mhc_pkg::MHC_LVL_ZERO;
  localparam mhc_pkg::mhc_level_t LM = mhc_pkg::MHC_LVL_MID;
  localparam mhc_pkg::mhc_level_t LH = mhc_pkg::MHC_LVL_HIGH;
  typedef struct packed {
    logic [3:0] term;
    logic cts_en;
    logic fit;
    logic master;
    mhc_pkg::mhc_level_t level;
    logic rts;
    logic kbd;
    logic lamp;
  } mhc_row_t;

  logic clk;
  logic rst;
  mhc_pkg::mhc_term_t term;
  mhc_pkg::mhc_modem_t modem;
  mhc_pkg::mhc_ctrl_t ctrl;
  mhc_pkg::mhc_level_t level;
  logic [7:0] cts_dly;
  logic key, ab_req, brk_j, fol_j, sw_net, dcd, ri, cts_en, fit, toggle;
  logic cts, pz, mreq, tx, mid_oe, high_oe, kbd, lamp, ab;
  int errors, total_checks, cyc, tx_run, tx_last, tx_rises, dtr_run, dtr_last, dtr_fall;
  int ab_cnt, t0;

  // Term {paper, on_line, power, wake}; expected line level and outputs beside them
  mhc_row_t rows [10] = '{
    '{4'hf, 1'h0, 1'h0, 1'h0, LM, 1'h1, 1'h1, 1'h0},
    '{4'hf, 1'h1, 1'h0, 1'h0, LH, 1'h1, 1'h1, 1'h1},
    '{4'hf, 1'h1, 1'h1, 1'h0, LZ, 1'h0, 1'h0, 1'h0},
    '{4'hf, 1'h1, 1'h1, 1'h1, LH, 1'h1, 1'h1, 1'h1},
    '{4'hf, 1'h0, 1'h1, 1'h1, LM, 1'h1, 1'h1, 1'h0},
    '{4'h7, 1'h1, 1'h0, 1'h0, LM, 1'h0, 1'h1, 1'h0},
    '{4'hb, 1'h1, 1'h0, 1'h0, LH, 1'h0, 1'h1, 1'h1},
    '{4'hd, 1'h1, 1'h0, 1'h0, LM, 1'h0, 1'h1, 1'h0},
    '{4'he, 1'h1, 1'h0, 1'h0, LM, 1'h0, 1'h1, 1'h0},
    '{4'hb, 1'h0, 1'h1, 1'h0, LZ, 1'h0, 1'h0, 1'h0}
  };

  assign modem = '{cts: cts, dcd: dcd, ri: ri};

  mhc_top #(.TICKS_PER_MS(TPM)) u_mhc_top (
    .i_core_clk(clk),
    .i_rst(rst),
    .i_term(term),
    .i_modem(modem),
    .i_key_data(key),
    .i_master_req(mreq),
    .i_permit_zero(pz),
    .i_answerback_req(ab_req),
    .i_break_inject_jumper(brk_j),
    .i_status_follow_jumper(fol_j),
    .i_switched_net(sw_net),
    .o_tx_data(tx),
    .o_modem(ctrl),
    .o_permit_mid_oe(mid_oe),
    .o_permit_high_oe(high_oe),
    .o_permit_level(level),
    .o_kbd_enable(kbd),
    .o_select_lamp(lamp),
    .o_answerback_send(ab)
  );

  mhc_far_side u_mhc_far_side (
    .i_core_clk(clk),
    .i_rst(rst),
    .i_rts(ctrl.rts),
    .i_cts_enable(cts_en),
    .i_cts_delay(cts_dly),
    .i_option_fitted(fit),
    .i_toggle(toggle),
    .o_cts(cts),
    .o_permit_zero(pz),
    .o_master_req(mreq)
  );

  // ****************************************
  // Clock, monitors and shared tasks
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Run lengths of outgoing data high and DTR low, answerback pulse count
  always @(posedge clk)
  begin
    cyc++;
    if (ab === 1'b1)
      ab_cnt++;
    if (tx === 1'b1)
    begin
      if (tx_run == 0)
        tx_rises++;
      tx_run++;
    end
    else
    begin
      if (tx_run > 0)
        tx_last = tx_run;
      tx_run = 0;
    end
    if (ctrl.dtr === 1'b0 && rst === 1'b0)
    begin
      if (dtr_run == 0)
        dtr_fall = cyc;
      dtr_run++;
    end
    else
    begin
      if (dtr_run > 0)
        dtr_last = dtr_run;
      dtr_run = 0;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic near(input string nm, input int ex, input int ac, input int tol);
    `CHK(nm, ex, (ac >= ex - tol && ac <= ex + tol) ? ex : ac)
  endtask

  task automatic set_master(input logic v);
    if (mreq !== v)
    begin
      toggle = 1'b1;
      tick(1);
      toggle = 1'b0;
    end
  endtask

  task automatic ask_answerback();
    ab_req = 1'b1;
    tick(2);
    ab_req = 1'b0;
  endtask

  task automatic chk_reset();
    `CHK("rst_level", LM, level)
    `CHK("rst_drive", 2'h2, {mid_oe, high_oe})
    `CHK("rst_modem", 3'h0, ctrl)
    `CHK("rst_outs", 4'h0, {tx, kbd, lamp, ab})
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog cuts a hang well past the expected run length
  initial
  begin
    #400000;
    errors++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    term = 4'hf;
    {key, ab_req, brk_j, fol_j, sw_net, ri, cts_en, fit, toggle} = 9'h000;
    dcd = 1'b1;
    cts_dly = 8'h02;
    tick(3);
    chk_reset();
    tick(2);
    rst = 1'b0;
    // Table of level, RTS, keyboard, lamp and originate cases
    foreach (rows[i])
    begin
      term = rows[i].term;
      cts_en = rows[i].cts_en;
      fit = rows[i].fit;
      set_master(rows[i].master);
      tick(20);
      `CHK("level", rows[i].level, level)
      `CHK("rts", rows[i].rts, ctrl.rts)
      `CHK("kbd", rows[i].kbd, kbd)
      `CHK("lamp", rows[i].lamp, lamp)
      `CHK("originate", rows[i].master, ctrl.originate)
      `CHK("one_drive", 1'b1, mid_oe ^ high_oe)
    end
    // Answerback held in M, sent in H, dropped in 0; slow modem
    set_master(1'b0);
    {term, fit, cts_en, cts_dly} = {4'hf, 2'h0, 8'h28};
    tick(10);
    t0 = ab_cnt;
    ask_answerback();
    tick(15);
    `CHK("ab_held", t0, ab_cnt)
    cts_en = 1'b1;
    tick(20);
    `CHK("slow_cts_mid", LM, level)
    tick(40);
    `CHK("slow_cts_high", LH, level)
    `CHK("ab_after_high", t0 + 1, ab_cnt)
    ask_answerback();
    tick(8);
    `CHK("ab_at_once", t0 + 2, ab_cnt)
    fit = 1'b1;
    tick(10);
    `CHK("zero_level", LZ, level)
    ask_answerback();
    tick(10);
    set_master(1'b1);
    tick(60);
    `CHK("ab_dropped", t0 + 2, ab_cnt)
    set_master(1'b0);
    fit = 1'b0;
    // Long keyboard break is cut off
    key = 1'b1;
    tick(700);
    key = 1'b0;
    tick(10);
    near("break_width", BRK, tx_last, 3);
    // Not-ready pulses: short passes, long truncated, jumper gates
    brk_j = 1'b1;
    term.paper_ok = 1'b0;
    tick(200);
    term.paper_ok = 1'b1;
    tick(20);
    near("nr_short", 200, tx_last, 3);
    term.on_line = 1'b0;
    tick(700);
    term.on_line = 1'b1;
    tick(20);
    near("nr_long", BRK, tx_last, 3);
    brk_j = 1'b0;
    t0 = tx_rises;
    term.power_ok = 1'b0;
    tick(300);
    term.power_ok = 1'b1;
    tick(20);
    `CHK("nr_no_jumper", t0, tx_rises)
    // DTR follows readiness with the status jumper
    fol_j = 1'b1;
    term.wake_done = 1'b0;
    tick(50);
    `CHK("dtr_follow_low", 1'b0, ctrl.dtr)
    term.wake_done = 1'b1;
    tick(10);
    `CHK("dtr_follow_high", 1'b1, ctrl.dtr)
    fol_j = 1'b0;
    // Reset in mid pulse clears it
    brk_j = 1'b1;
    term.paper_ok = 1'b0;
    tick(50);
    rst = 1'b1;
    term.paper_ok = 1'b1;
    tick(3);
    chk_reset();
    rst = 1'b0;
    t0 = tx_rises;
    tick(30);
    `CHK("no_pulse_after_reset", t0, tx_rises)
    brk_j = 1'b0;
    // Carrier loss outside switched use leaves DTR alone
    t0 = dtr_fall;
    dcd = 1'b0;
    tick(5000 * TPM + 200);
    `CHK("no_disc_unswitched", t0, dtr_fall)
    dcd = 1'b1;
    // Carrier loss, then ring without carrier, in switched use
    sw_net = 1'b1;
    tick(10);
    dcd = 1'b0;
    t0 = cyc;
    tick(5000 * TPM + 200);
    near("loss_delay", 5000 * TPM, dtr_fall - t0, 6);
    near("loss_pulse", 70 * TPM, dtr_last, 3);
    ri = 1'b1;
    t0 = cyc;
    tick(4);
    ri = 1'b0;
    tick(15000 * TPM + 200);
    near("ring_delay", 15000 * TPM, dtr_fall - t0, 6);
    near("ring_pulse", 70 * TPM, dtr_last, 3);
    report_and_stop();
  end
endmodule
